// [rtl/ecpm_prescale.sv]
`default_nettype none
module ecpm_prescale (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // tap select
  input  wire logic [1:0] src_sel_i,
  // count source tick
  output logic            tick_o
);
  // ---------------------------------------------------------------
  // tap decode
  // ---------------------------------------------------------------
  function automatic logic [8:0] tap_mask(input logic [1:0] sel);
    case (sel)
      ecpm_pkg::SRC_DIV2:   tap_mask = ecpm_pkg::MASK_DIV2;
      ecpm_pkg::SRC_DIV16:  tap_mask = ecpm_pkg::MASK_DIV16;
      ecpm_pkg::SRC_DIV64:  tap_mask = ecpm_pkg::MASK_DIV64;
      default:              tap_mask = ecpm_pkg::MASK_DIV512;
    endcase
  endfunction

  logic [8:0] div_q;
  logic [8:0] div_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    div_d  = div_q + 9'h001;
    tick_d = ((div_q & tap_mask(src_sel_i)) == tap_mask(src_sel_i));
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q  <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule
`default_nettype wire

// [rtl/ecpm_timer.sv]
`default_nettype none
module ecpm_timer #(
  parameter int CHANNEL = 0
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // external event pin
  input  wire logic        ext_timer_input_i,
  // interrupt request bit and acceptance
  input  wire logic        irq_accept_i,
  output logic             irq_req_o,
  // status
  output logic             running_o
);
  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic MEAS_OK = (CHANNEL < ecpm_pkg::MEAS_CHANNELS);

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        req;
  logic        wr_go;
  logic        rd_go;

  assign req   = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~wait_q;
  assign rd_go = avs_read_i & wait_q;

  // ---------------------------------------------------------------
  // pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic pin_rise;
  logic pin_fall;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_timer_input_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_rise = pin_s2_q & ~pin_s3_q;
  assign pin_fall = ~pin_s2_q & pin_s3_q;

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  logic        start_q;
  logic        start_d;
  logic        start_prev_q;
  logic [7:0]  mode_q;
  logic [7:0]  mode_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] reload_q;
  logic [15:0] reload_d;
  logic        irq_q;
  logic        irq_d;
  logic        ovf_q;
  logic        ovf_d;
  logic        ovf_clr_q;
  logic        ovf_clr_d;
  logic        first_q;
  logic        first_d;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      ecpm_pkg::EDGE_FALL: edge_hit = fall;
      ecpm_pkg::EDGE_RISE: edge_hit = rise;
      ecpm_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default:             edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    lane_merge = old;
    if (be[0]) begin
      lane_merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      lane_merge[15:8] = wd[15:8];
    end
  endfunction

  logic [1:0] op_sel;
  logic [1:0] edge_sel;
  logic [1:0] src_sel;
  logic       ev_mode;
  logic       ms_mode;
  logic       valid_edge;
  logic       tick;
  logic       underflow;
  logic       start_rise;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_timer;
  logic       wr_irq;

  assign op_sel     = mode_q[ecpm_pkg::MODE_OP_LSB +: 2];
  assign edge_sel   = mode_q[ecpm_pkg::MODE_EDGE_LSB +: 2];
  assign src_sel    = mode_q[ecpm_pkg::MODE_SRC_LSB +: 2];
  assign ev_mode    = (op_sel == ecpm_pkg::OP_EVENT);
  assign ms_mode    = (op_sel == ecpm_pkg::OP_MEASURE) & MEAS_OK;
  assign valid_edge = start_q & edge_hit(edge_sel, pin_rise, pin_fall);
  assign underflow  = ev_mode & valid_edge & (cnt_q == 16'h0000);
  assign start_rise = start_q & ~start_prev_q;
  assign wr_ctrl    = wr_go & (avs_address_i == ecpm_pkg::ADDR_CTRL) & avs_byteenable_i[0];
  assign wr_mode    = wr_go & (avs_address_i == ecpm_pkg::ADDR_MODE) & avs_byteenable_i[0];
  assign wr_timer   = wr_go & (avs_address_i == ecpm_pkg::ADDR_TIMER);
  assign wr_irq     = wr_go & (avs_address_i == ecpm_pkg::ADDR_IRQ) & avs_byteenable_i[0];

  // ---------------------------------------------------------------
  // count source prescaler
  // ---------------------------------------------------------------
  ecpm_prescale u_prescale (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .src_sel_i (src_sel),
    .tick_o    (tick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    start_d   = start_q;
    mode_d    = mode_q;
    cnt_d     = cnt_q;
    reload_d  = reload_q;
    irq_d     = irq_q;
    ovf_d     = ovf_q;
    ovf_clr_d = ovf_clr_q;
    first_d   = first_q;
    // software side
    if (wr_ctrl) begin
      start_d = avs_writedata_i[ecpm_pkg::CTRL_START_BIT];
    end
    if (wr_mode) begin
      mode_d = avs_writedata_i[7:0];
      mode_d[ecpm_pkg::MODE_OVF_BIT] = 1'b0;
      if (start_q) begin
        ovf_clr_d = 1'b1;
      end
      if (ms_mode && (avs_writedata_i[ecpm_pkg::MODE_EDGE_LSB +: 2] != edge_sel)) begin
        irq_d = 1'b1;
      end
    end
    if (wr_timer && !ms_mode) begin
      reload_d = lane_merge(reload_q, avs_writedata_i, avs_byteenable_i);
      if (!start_q) begin
        cnt_d = lane_merge(cnt_q, avs_writedata_i, avs_byteenable_i);
      end
    end
    if (wr_irq && !avs_writedata_i[ecpm_pkg::IRQ_REQ_BIT]) begin
      irq_d = 1'b0;
    end
    if (wr_irq && avs_writedata_i[ecpm_pkg::IRQ_REQ_BIT]) begin
      irq_d = 1'b1;
    end
    if (irq_accept_i) begin
      irq_d = 1'b0;
    end
    if (start_rise) begin
      first_d = 1'b1;
    end
    // hardware side; sets placed last so they win over clears
    if (ev_mode && valid_edge) begin
      if (underflow) begin
        cnt_d = reload_q;
        irq_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 16'h0001;
      end
    end
    if (ms_mode && start_q) begin
      if (tick && ovf_clr_q) begin
        ovf_d     = 1'b0;
        ovf_clr_d = 1'b0;
      end
      if (valid_edge) begin
        reload_d = cnt_q;
        cnt_d    = 16'h0000;
        first_d  = 1'b0;
        if (!first_q) begin
          irq_d = 1'b1;
        end
      end else if (tick) begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == ecpm_pkg::ALL_ONES) begin
          irq_d = 1'b1;
          ovf_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q      <= 1'b0;
      start_prev_q <= 1'b0;
      mode_q       <= ecpm_pkg::MODE_RST;
      cnt_q        <= ecpm_pkg::TIMER_RST;
      reload_q     <= ecpm_pkg::TIMER_RST;
      irq_q        <= 1'b0;
      ovf_q        <= 1'b0;
      ovf_clr_q    <= 1'b0;
      first_q      <= 1'b0;
    end else begin
      start_q      <= start_d;
      start_prev_q <= start_q;
      mode_q       <= mode_d;
      cnt_q        <= cnt_d;
      reload_q     <= reload_d;
      irq_q        <= irq_d;
      ovf_q        <= ovf_d;
      ovf_clr_q    <= ovf_clr_d;
      first_q      <= first_d;
    end
  end

  // ---------------------------------------------------------------
  // read data and wait state
  // ---------------------------------------------------------------
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if (req && wait_q) begin
      wait_d = 1'b0;
    end
    if (rd_go) begin
      rdata_d = 32'h0000_0000;
      case (avs_address_i)
        ecpm_pkg::ADDR_CTRL: begin
          rdata_d[ecpm_pkg::CTRL_START_BIT] = start_q;
        end
        ecpm_pkg::ADDR_MODE: begin
          rdata_d[7:0] = mode_q;
          rdata_d[ecpm_pkg::MODE_OVF_BIT] = ovf_q;
        end
        ecpm_pkg::ADDR_TIMER: begin
          if (ms_mode) begin
            rdata_d[15:0] = reload_q;
          end else if (underflow) begin
            rdata_d[15:0] = ecpm_pkg::ALL_ONES;
          end else begin
            rdata_d[15:0] = cnt_q;
          end
        end
        ecpm_pkg::ADDR_IRQ: begin
          rdata_d[ecpm_pkg::IRQ_REQ_BIT] = irq_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_req_o         = irq_q;
  assign running_o         = start_q;
endmodule
`default_nettype wire

// [shared/ecpm_pkg.sv]
`default_nettype none
package ecpm_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL  = 5'h00;
  localparam logic [4:0] ADDR_MODE  = 5'h04;
  localparam logic [4:0] ADDR_TIMER = 5'h08;
  localparam logic [4:0] ADDR_IRQ   = 5'h0C;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int MODE_OP_LSB    = 0;
  localparam int MODE_EDGE_LSB  = 2;
  localparam int MODE_OVF_BIT   = 5;
  localparam int MODE_SRC_LSB   = 6;
  localparam int IRQ_REQ_BIT    = 0;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_EVENT   = 2'h1;
  localparam logic [1:0] OP_MEASURE = 2'h2;
  localparam logic [1:0] EDGE_FALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_BOTH  = 2'h2;
  localparam logic [1:0] SRC_DIV2   = 2'h0;
  localparam logic [1:0] SRC_DIV16  = 2'h1;
  localparam logic [1:0] SRC_DIV64  = 2'h2;
  localparam logic [1:0] SRC_DIV512 = 2'h3;
  localparam logic [8:0] MASK_DIV2   = 9'h001;
  localparam logic [8:0] MASK_DIV16  = 9'h00F;
  localparam logic [8:0] MASK_DIV64  = 9'h03F;
  localparam logic [8:0] MASK_DIV512 = 9'h1FF;
  localparam int MEAS_CHANNELS = 2;
  // ---------------------------------------------------------------
  // reset values and the all-ones count
  // ---------------------------------------------------------------
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [7:0]  MODE_RST  = 8'h01;
  localparam logic [15:0] ALL_ONES  = 16'hFFFF;
endpackage
`default_nettype wire

// [tb/ecpm_pin_model.sv]
`default_nettype none
module ecpm_pin_model (
  // clock
  input  wire logic clock_i,
  // driven pin
  output var  logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // pin level driver
  // ---------------------------------------------------------------
  initial pin_o = 1'b0;
  // new level after an edge, held for a number of clocks
  task automatic drive(input logic lvl, input int hold);
    @(posedge clock_i);
    pin_o <= lvl;
    repeat (hold - 1) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// [tb/ecpm_timer_asserts.sv]
`default_nettype none
module ecpm_timer_asserts (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // avalon-mm slave
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // pin and interrupt
  input wire logic        ext_timer_input_i,
  input wire logic        irq_accept_i,
  input wire logic        irq_req_o,
  input wire logic        running_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // completed writes and properties
  // ---------------------------------------------------------------
  logic ctl_wr;
  logic irq_wr;
  assign ctl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == ecpm_pkg::ADDR_CTRL && avs_byteenable_i[0];
  assign irq_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == ecpm_pkg::ADDR_IRQ && avs_byteenable_i[0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_start_follow: assert property (ctl_wr |=> running_o == $past(avs_writedata_i[0]))
    else $error("start bit not taken from write");
  chk_run_change: assert property ($changed(running_o) |-> $past(ctl_wr))
    else $error("start bit changed without write");
  chk_ctrl_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == ecpm_pkg::ADDR_CTRL
    |-> avs_readdata_o[0] == running_o) else $error("start bit read back wrong");
  chk_irq_cause: assert property ($rose(irq_req_o)
    |-> $past(running_o) || $past(running_o, 2) || $past(avs_write_i)) else $error("request without cause");
  chk_irq_hold: assert property (irq_req_o && !irq_accept_i && !irq_wr |=> irq_req_o)
    else $error("request bit dropped");
  chk_irq_swset: assert property (irq_wr && avs_writedata_i[0] |=> irq_req_o)
    else $error("request bit not set by write");
  chk_irq_swclr: assert property (irq_wr && !avs_writedata_i[0] && !running_o && !$past(running_o)
    |=> !irq_req_o) else $error("request bit not cleared by write");
  chk_accept_clr: assert property (irq_accept_i && !running_o && !$past(running_o) && !avs_write_i
    |=> !irq_req_o) else $error("request bit not cleared by accept");
endmodule
bind ecpm_timer ecpm_timer_asserts u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .ext_timer_input_i(ext_timer_input_i), .irq_accept_i(irq_accept_i), .irq_req_o(irq_req_o),
  .running_o(running_o)
);
`default_nettype wire

// [tb/ecpm_timer_tb.sv]
`default_nettype none
module ecpm_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        ext_timer_input_i;
  logic        irq_accept_i = 1'b0;
  logic        irq_req_o;
  logic        running_o;
  logic [31:0] rdat;
  int          miscompares = 0;
  int          checks = 0;
  int          dv [4] = '{32'h2, 32'h10, 32'h40, 32'h200};
  always #5 clock_i = ~clock_i;
  ecpm_timer dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ext_timer_input_i(ext_timer_input_i), .irq_accept_i(irq_accept_i), .irq_req_o(irq_req_o),
    .running_o(running_o)
  );
  ecpm_pin_model pin (.clock_i(clock_i), .pin_o(ext_timer_input_i));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rdat = avs_readdata_o;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest_o});
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rdat);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("running", 32'h0, running_o);
    chk("irq", 32'h0, irq_req_o);
    rdchk("mode", ecpm_pkg::ADDR_MODE, {24'h0, ecpm_pkg::MODE_RST});
    rdchk("timer", ecpm_pkg::ADDR_TIMER, 32'h0);
    rdchk("unmapped", 5'h10, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_event(input logic [1:0] code);
    int   v;
    logic lvl;
    v = 0;
    lvl = ext_timer_input_i;
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, ecpm_pkg::ADDR_MODE, {28'h0, code, ecpm_pkg::OP_EVENT});
    bus(1'b1, ecpm_pkg::ADDR_TIMER, 32'h2);
    bus(1'b1, ecpm_pkg::ADDR_IRQ, 32'h0);
    rdchk("stopped read", ecpm_pkg::ADDR_TIMER, 32'h2);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h1);
    while (v < 3) begin
      lvl = !lvl;
      pin.drive(lvl, 6);
      if (code == ecpm_pkg::EDGE_BOTH || lvl == (code == ecpm_pkg::EDGE_RISE)) v++;
      chk("underflow irq", {31'h0, v == 3}, irq_req_o);
    end
    rdchk("reloaded", ecpm_pkg::ADDR_TIMER, 32'h2);
    $display("t_event done");
  endtask
  task automatic t_live();
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, ecpm_pkg::ADDR_MODE, {28'h0, ecpm_pkg::EDGE_BOTH, ecpm_pkg::OP_EVENT});
    bus(1'b1, ecpm_pkg::ADDR_TIMER, 32'h1);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h1);
    bus(1'b1, ecpm_pkg::ADDR_TIMER, 32'h4);
    rdchk("live count", ecpm_pkg::ADDR_TIMER, 32'h1);
    pin.drive(!ext_timer_input_i, 6);
    pin.drive(!ext_timer_input_i, 6);
    rdchk("new reload", ecpm_pkg::ADDR_TIMER, 32'h4);
    pin.drive(!ext_timer_input_i, 6);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    pin.drive(!ext_timer_input_i, 6);
    rdchk("halted", ecpm_pkg::ADDR_TIMER, 32'h3);
    bus(1'b1, ecpm_pkg::ADDR_TIMER, 32'h0);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h1);
    fork
      pin.drive(!ext_timer_input_i, 6);
      begin
        repeat (3) @(posedge clock_i);
        rdchk("reload instant", ecpm_pkg::ADDR_TIMER, {16'h0, ecpm_pkg::ALL_ONES});
      end
    join
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    $display("t_live done");
  endtask
  task automatic t_irq();
    bus(1'b1, ecpm_pkg::ADDR_IRQ, 32'h1);
    repeat (5) @(posedge clock_i);
    chk("irq held", 32'h1, irq_req_o);
    irq_accept_i <= 1'b1;
    @(posedge clock_i);
    irq_accept_i <= 1'b0;
    @(posedge clock_i);
    chk("irq accepted", 32'h0, irq_req_o);
    bus(1'b1, ecpm_pkg::ADDR_IRQ, 32'h1);
    bus(1'b1, ecpm_pkg::ADDR_IRQ, 32'h0);
    chk("irq cleared", 32'h0, irq_req_o);
    $display("t_irq done");
  endtask
  task automatic t_measure(input logic [1:0] src, input logic [1:0] code);
    logic [31:0] ev;
    logic [31:0] m;
    ev = (code == ecpm_pkg::EDGE_BOTH) ? 32'h4 : 32'hA;
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, ecpm_pkg::ADDR_MODE, {24'h0, src, 2'h0, code, ecpm_pkg::OP_MEASURE});
    bus(1'b1, ecpm_pkg::ADDR_IRQ, 32'h0);
    pin.drive(1'b0, 8);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      pin.drive(1'b1, dv[src] * 4);
      if (i == 0) chk("first edge irq", 32'h0, irq_req_o);
      pin.drive(1'b0, dv[src] * 6);
    end
    bus(1'b1, ecpm_pkg::ADDR_TIMER, 32'hFFFF);
    bus(1'b0, ecpm_pkg::ADDR_TIMER, 32'h0);
    m = rdat & 32'h0000FFFF;
    chk("measured", (m == ev - 32'h1) ? m : ev, m);
    chk("edge irq", 32'h1, irq_req_o);
    $display("t_measure done");
  endtask
  task automatic t_ovf();
    logic [31:0] md;
    logic [31:0] fl;
    md = {24'h0, ecpm_pkg::SRC_DIV2, 2'h0, ecpm_pkg::EDGE_FALL, ecpm_pkg::OP_MEASURE};
    fl = md | (32'h1 << ecpm_pkg::MODE_OVF_BIT);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, ecpm_pkg::ADDR_MODE, {28'h0, ecpm_pkg::EDGE_FALL, ecpm_pkg::OP_EVENT});
    bus(1'b1, ecpm_pkg::ADDR_TIMER, 32'hFFFF);
    bus(1'b1, ecpm_pkg::ADDR_MODE, md);
    bus(1'b1, ecpm_pkg::ADDR_IRQ, 32'h0);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h1);
    rdchk("overflow flag", ecpm_pkg::ADDR_MODE, fl);
    chk("overflow irq", 32'h1, irq_req_o);
    bus(1'b1, ecpm_pkg::ADDR_MODE, fl);
    rdchk("flag cleared", ecpm_pkg::ADDR_MODE, md);
    chk("irq kept", 32'h1, irq_req_o);
    bus(1'b1, ecpm_pkg::ADDR_CTRL, 32'h0);
    $display("t_ovf done");
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    $display("[FAIL] watchdog expected done seen timeout");
    results();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_event(ecpm_pkg::EDGE_FALL);
    t_event(ecpm_pkg::EDGE_RISE);
    t_event(ecpm_pkg::EDGE_BOTH);
    t_live();
    t_irq();
    t_measure(ecpm_pkg::SRC_DIV2, ecpm_pkg::EDGE_FALL);
    t_measure(ecpm_pkg::SRC_DIV16, ecpm_pkg::EDGE_RISE);
    t_measure(ecpm_pkg::SRC_DIV64, ecpm_pkg::EDGE_BOTH);
    t_measure(ecpm_pkg::SRC_DIV512, ecpm_pkg::EDGE_FALL);
    t_ovf();
    results();
  end
endmodule
`default_nettype wire
